// ---- common/frt_pkg.sv ----
// package of the free running timer: register offsets, field positions,
// reset values, clock selections and bus answer codes.
// assumes a 32-bit AXI4-Lite register bus with byte addresses and 8-bit registers.

package frt_pkg;

	////////////////////////////////////////////////////////////////////////////
	// bus geometry and answers
	localparam int          ADDR_W       = 8;
	localparam int          BYTE_W       = 8;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets, one aligned word each
	localparam logic [7:0]  OFF_CTRL_ONE = 8'h00;
	localparam logic [7:0]  OFF_CTRL_TWO = 8'h04;
	localparam logic [7:0]  OFF_STATUS   = 8'h08;
	localparam logic [7:0]  OFF_CNT_HI   = 8'h0C;
	localparam logic [7:0]  OFF_CNT_LO   = 8'h10;
	localparam logic [7:0]  OFF_SHD_HI   = 8'h14;
	localparam logic [7:0]  OFF_SHD_LO   = 8'h18;
	localparam logic [7:0]  OFF_CAP1_HI  = 8'h1C;
	localparam logic [7:0]  OFF_CAP1_LO  = 8'h20;
	localparam logic [7:0]  OFF_CAP2_HI  = 8'h24;
	localparam logic [7:0]  OFF_CAP2_LO  = 8'h28;

	////////////////////////////////////////////////////////////////////////////
	// timer_control_one fields
	localparam int          C1_EDGE_ONE  = 0;
	localparam int          C1_WRAP_IE   = 1;
	localparam int          C1_CAP_IE    = 2;
	// timer_control_two fields
	localparam int          C2_CLK_LSB   = 0;
	localparam int          C2_CLK_MSB   = 1;
	localparam int          C2_EDGE_TWO  = 2;
	localparam int          C2_EXT_EDGE  = 3;
	localparam int          C2_SPM       = 4;
	localparam int          C2_PWM       = 5;
	// timer_status_reg fields
	localparam int          ST_CAP_ONE   = 0;
	localparam int          ST_CAP_TWO   = 1;
	localparam int          ST_WRAP      = 2;
	localparam int          FLAG_N       = 3;

	////////////////////////////////////////////////////////////////////////////
	// reset values and counter constants
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [15:0] COUNT_RESET  = 16'hFFFC;
	localparam logic [15:0] COUNT_TOP    = 16'hFFFF;

	// prescaler terminal counts for divide by 2, 4 and 8
	localparam logic [2:0]  PRE_LAST_2   = 3'h1;
	localparam logic [2:0]  PRE_LAST_4   = 3'h3;
	localparam logic [2:0]  PRE_LAST_8   = 3'h7;

	typedef enum logic [1:0] {
		FRT_CLK_DIV2 = 2'h0,
		FRT_CLK_DIV4 = 2'h1,
		FRT_CLK_DIV8 = 2'h2,
		FRT_CLK_EXT  = 2'h3
	} frt_clk_sel_t;

endpackage

// ---- src/frt_edge_det.sv ----
// pin edge detector: two-flop synchroniser followed by a polarity-selected edge pulse.
// assumes the pin is asynchronous to aclk; the pulse is one aclk cycle wide.
`timescale 1ns/100ps

module frt_edge_det (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin,
	input  wire logic rise_sel,
	output logic      edge_pulse
);

	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;
	logic hit;

	// polarity: 1 picks rising, 0 picks falling; only the second stage is examined
	assign hit = rise_sel ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg);

	// synchroniser, history and registered pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg  <= 1'b0;
			sync2_reg  <= 1'b0;
			prev_reg   <= 1'b0;
			edge_pulse <= 1'b0;
		end else begin
			sync1_reg  <= pin;
			sync2_reg  <= sync1_reg;
			prev_reg   <= sync2_reg;
			edge_pulse <= hit;
		end
	end

endmodule // frt_edge_det

// ---- src/frt_timer.sv ----
// free running 16-bit timer with prescaler, external clock and two capture channels.
// assumes an AXI4-Lite master on aclk, asynchronous pins, and a cpu mask level input.
// Function
// [RQ1] 16-bit free running up-counter read as high and low byte, prescaled
// [RQ2] internal count rate is clock over 2, 4 or 8 by clock select
// [RQ3] both clock select bits set picks the external clock pin
// [RQ4] external edge select bit picks which pin transition counts
// [RQ5] external counter steps are resynchronised to the cpu clock
// [RQ6] external clock leaves at least four cpu clocks between active edges
// [RQ7] shadow counter copy whose low byte read never clears wrap flag
// [RQ8] any write to either counter low byte reloads FFFCh
// [RQ9] counter resets to FFFCh, the only reload value, in every mode
// [RQ10] high byte read freezes low byte until low byte is read
// [RQ11] after a finished pair, low byte alone reads the live count
// [RQ12] wrap from FFFFh to 0000h sets the wrap flag
// [RQ13] wrap interrupt needs enable and clear cpu mask, else stays pending
// [RQ14] wrap flag clears by status read while set, then count low access
// [RQ15] counter runs in wait, stops in halt, resumes from held count
// [RQ16] each capture channel latches the count on its active pin edge
// [RQ17] per channel edge select, channel two in control two, one in one
// [RQ18] capture sets channel flag, interrupt on shared enable and clear mask
// [RQ19] capture flag clears by status read while set, then capture low access
// [RQ20] capture high read blocks capture and flag until capture low read
// [RQ21] capture register always holds the latest captured count
// [RQ22] single pulse or pulse width mode leaves only channel two capturing
// [RQ23] wrap and capture requests are ORed into one timer interrupt
`timescale 1ns/100ps

module frt_timer (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ext_clock_pin,
	input  wire logic        capture_pin_one,
	input  wire logic        capture_pin_two,
	input  wire logic        halt_mode,
	input  wire logic        cpu_irq_mask,
	output logic             timer_irq
);

	////////////////////////////////////////////////////////////////////////////
	// state

	logic [7:0]                   timer_control_one;
	logic [7:0]                   timer_control_two;
	logic [15:0]                  count_reg;
	logic [15:0]                  count_next;
	logic [2:0]                   pre_reg;
	logic [2:0]                   pre_next;
	logic [1:0][7:0]              lo_buf_reg;
	logic [1:0]                   buf_valid_reg;
	logic [1:0][15:0]             capture_value_reg;
	logic [1:0]                   cap_lock_reg;
	logic [frt_pkg::FLAG_N-1:0]   flag_reg;
	logic [frt_pkg::FLAG_N-1:0]   flag_next;
	logic [frt_pkg::FLAG_N-1:0]   arm_reg;
	logic [frt_pkg::FLAG_N-1:0]   arm_next;
	logic                         aw_got_reg;
	logic                         w_got_reg;
	logic [7:0]                   awaddr_reg;
	logic [7:0]                   wdata_reg;
	logic                         wstrb0_reg;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return hit(a, frt_pkg::OFF_CTRL_ONE) | hit(a, frt_pkg::OFF_CTRL_TWO) | hit(a, frt_pkg::OFF_STATUS)
			| hit(a, frt_pkg::OFF_CNT_HI) | hit(a, frt_pkg::OFF_CNT_LO) | hit(a, frt_pkg::OFF_SHD_HI)
			| hit(a, frt_pkg::OFF_SHD_LO) | hit(a, frt_pkg::OFF_CAP1_HI) | hit(a, frt_pkg::OFF_CAP1_LO)
			| hit(a, frt_pkg::OFF_CAP2_HI) | hit(a, frt_pkg::OFF_CAP2_LO);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// bus strobes: one write and one read at a time

	wire wr_do = aw_got_reg & w_got_reg;
	wire rd_do = s_axi_arvalid & s_axi_arready;
	wire [7:0] ra = s_axi_araddr;

	assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	// access strobes with side effects
	wire wr_lane   = wr_do & wstrb0_reg;
	wire sts_rd    = rd_do & hit(ra, frt_pkg::OFF_STATUS);
	wire rd_cnt_hi = rd_do & hit(ra, frt_pkg::OFF_CNT_HI);
	wire rd_cnt_lo = rd_do & hit(ra, frt_pkg::OFF_CNT_LO);
	wire rd_shd_hi = rd_do & hit(ra, frt_pkg::OFF_SHD_HI);
	wire rd_shd_lo = rd_do & hit(ra, frt_pkg::OFF_SHD_LO);
	wire [1:0] rd_cap_hi = {rd_do & hit(ra, frt_pkg::OFF_CAP2_HI), rd_do & hit(ra, frt_pkg::OFF_CAP1_HI)};
	wire [1:0] rd_cap_lo = {rd_do & hit(ra, frt_pkg::OFF_CAP2_LO), rd_do & hit(ra, frt_pkg::OFF_CAP1_LO)};
	wire [1:0] wr_cap_lo = {wr_do & hit(awaddr_reg, frt_pkg::OFF_CAP2_LO),
		wr_do & hit(awaddr_reg, frt_pkg::OFF_CAP1_LO)};
	wire wr_cnt_lo = wr_do & hit(awaddr_reg, frt_pkg::OFF_CNT_LO);
	wire reload    = wr_cnt_lo | (wr_do & hit(awaddr_reg, frt_pkg::OFF_SHD_LO)); // [RQ8]

	////////////////////////////////////////////////////////////////////////////
	// pin edge detection: ext clock, capture one, capture two

	wire [2:0] pins     = {capture_pin_two, capture_pin_one, ext_clock_pin};
	wire [2:0] rise_sel = {timer_control_two[frt_pkg::C2_EDGE_TWO],  // [RQ17]
		timer_control_one[frt_pkg::C1_EDGE_ONE],                       // [RQ17]
		timer_control_two[frt_pkg::C2_EXT_EDGE]};                      // [RQ4]
	logic [2:0] pin_edge;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_edge
			frt_edge_det u_edge (
				.aclk       (aclk),
				.aresetn    (aresetn),
				.pin        (pins[gi]),
				.rise_sel   (rise_sel[gi]),
				.edge_pulse (pin_edge[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// prescaler and count step

	wire frt_pkg::frt_clk_sel_t clk_sel =
		frt_pkg::frt_clk_sel_t'(timer_control_two[frt_pkg::C2_CLK_MSB:frt_pkg::C2_CLK_LSB]);
	wire [2:0] pre_last = (clk_sel == frt_pkg::FRT_CLK_DIV2) ? frt_pkg::PRE_LAST_2 :
		(clk_sel == frt_pkg::FRT_CLK_DIV4) ? frt_pkg::PRE_LAST_4 : frt_pkg::PRE_LAST_8; // [RQ2]
	wire use_ext  = (clk_sel == frt_pkg::FRT_CLK_EXT);                                 // [RQ3]
	wire int_tick = (pre_reg >= pre_last);
	// halt freezes the prescaler and the count step, but a low byte write still reloads the count; wait mode has no effect here
	wire tick     = ~halt_mode & (use_ext ? pin_edge[0] : int_tick);                    // [RQ5] [RQ15]
	wire wrap_evt = tick & ~reload & (count_reg == frt_pkg::COUNT_TOP);                 // [RQ12]

	assign pre_next   = (halt_mode) ? pre_reg : (use_ext | int_tick) ? 3'h0 : pre_reg + 3'h1;
	assign count_next = reload ? frt_pkg::COUNT_RESET : tick ? count_reg + 16'h0001 : count_reg; // [RQ1]

	////////////////////////////////////////////////////////////////////////////
	// capture gating: channel one is lent to the pulse modes

	wire pulse_mode = timer_control_two[frt_pkg::C2_SPM] | timer_control_two[frt_pkg::C2_PWM];
	wire [1:0] cap_take = {pin_edge[2] & ~cap_lock_reg[1],
		pin_edge[1] & ~cap_lock_reg[0] & ~pulse_mode};                          // [RQ20] [RQ22]

	////////////////////////////////////////////////////////////////////////////
	// flags: a set in the clearing cycle wins

	wire [frt_pkg::FLAG_N-1:0] flag_set = {wrap_evt, cap_take};                  // [RQ18]
	wire [frt_pkg::FLAG_N-1:0] clr_acc  = {rd_cnt_lo | wr_cnt_lo, rd_cap_lo | wr_cap_lo};
	wire [frt_pkg::FLAG_N-1:0] clr_fire = arm_reg & clr_acc;                     // [RQ14] [RQ19]

	assign flag_next = flag_set | (flag_reg & ~clr_fire);
	// arming only counts flags that were set when the status read happened
	assign arm_next  = (arm_reg & ~clr_fire & flag_next) | (sts_rd ? flag_reg : 3'h0);

	// one request line; pending flags stay until enable and mask allow
	wire wrap_req = flag_reg[frt_pkg::ST_WRAP] & timer_control_one[frt_pkg::C1_WRAP_IE];    // [RQ13]
	wire cap_req  = (flag_reg[frt_pkg::ST_CAP_ONE] | flag_reg[frt_pkg::ST_CAP_TWO])
		& timer_control_one[frt_pkg::C1_CAP_IE];                                       // [RQ18]
	assign timer_irq = ~cpu_irq_mask & (wrap_req | cap_req);                            // [RQ23]

	////////////////////////////////////////////////////////////////////////////
	// read data selection

	wire [7:0] cnt_lo_val = buf_valid_reg[0] ? lo_buf_reg[0] : count_reg[7:0];   // [RQ10] [RQ11]
	wire [7:0] shd_lo_val = buf_valid_reg[1] ? lo_buf_reg[1] : count_reg[7:0];   // [RQ7]
	wire [7:0] rd_byte =
		hit(ra, frt_pkg::OFF_CTRL_ONE) ? timer_control_one :
		hit(ra, frt_pkg::OFF_CTRL_TWO) ? timer_control_two :
		hit(ra, frt_pkg::OFF_STATUS)   ? {5'h00, flag_reg} :
		hit(ra, frt_pkg::OFF_CNT_HI)   ? count_reg[15:8] :
		hit(ra, frt_pkg::OFF_CNT_LO)   ? cnt_lo_val :
		hit(ra, frt_pkg::OFF_SHD_HI)   ? count_reg[15:8] :
		hit(ra, frt_pkg::OFF_SHD_LO)   ? shd_lo_val :
		hit(ra, frt_pkg::OFF_CAP1_HI)  ? capture_value_reg[0][15:8] :
		hit(ra, frt_pkg::OFF_CAP1_LO)  ? capture_value_reg[0][7:0] :
		hit(ra, frt_pkg::OFF_CAP2_HI)  ? capture_value_reg[1][15:8] :
		hit(ra, frt_pkg::OFF_CAP2_LO)  ? capture_value_reg[1][7:0] : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// bus channel registers

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			awaddr_reg   <= 8'h00;
			wdata_reg    <= 8'h00;
			wstrb0_reg   <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= frt_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end else if (wr_do) begin
				aw_got_reg <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_got_reg  <= 1'b1;
				wdata_reg  <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end else if (wr_do) begin
				w_got_reg <= 1'b0;
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(awaddr_reg) ? frt_pkg::RESP_OKAY : frt_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= frt_pkg::RESP_OKAY;
		end else if (rd_do) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= mapped(ra) ? frt_pkg::RESP_OKAY : frt_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers; clock select written while running takes the next step

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_control_one <= frt_pkg::CTRL_RESET;
			timer_control_two <= frt_pkg::CTRL_RESET;
		end else if (wr_lane) begin
			if (hit(awaddr_reg, frt_pkg::OFF_CTRL_ONE))
				timer_control_one <= wdata_reg;
			if (hit(awaddr_reg, frt_pkg::OFF_CTRL_TWO))
				timer_control_two <= wdata_reg;
		end
	end

	// counter, prescaler and flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= frt_pkg::COUNT_RESET;                                 // [RQ9]
			pre_reg   <= 3'h0;
			flag_reg  <= 3'h0;
			arm_reg   <= 3'h0;
		end else begin
			count_reg <= count_next;
			pre_reg   <= pre_next;
			flag_reg  <= flag_next;
			arm_reg   <= arm_next;
		end
	end

	// low byte buffers: index 0 main counter, 1 shadow copy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lo_buf_reg    <= '0;
			buf_valid_reg <= 2'h0;
		end else begin
			// repeated high reads do not refresh a pending buffer
			if (rd_cnt_hi & ~buf_valid_reg[0]) begin
				lo_buf_reg[0]    <= count_reg[7:0];                            // [RQ10]
				buf_valid_reg[0] <= 1'b1;
			end else if (rd_cnt_lo) begin
				buf_valid_reg[0] <= 1'b0;                                      // [RQ11]
			end
			if (rd_shd_hi & ~buf_valid_reg[1]) begin
				lo_buf_reg[1]    <= count_reg[7:0];
				buf_valid_reg[1] <= 1'b1;
			end else if (rd_shd_lo) begin
				buf_valid_reg[1] <= 1'b0;
			end
		end
	end

	// capture registers and high-read locks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_value_reg <= '0;
			cap_lock_reg      <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (cap_take[i])
					capture_value_reg[i] <= count_reg;                         // [RQ16] [RQ21]
				if (rd_cap_hi[i])
					cap_lock_reg[i] <= 1'b1;                                   // [RQ20]
				else if (rd_cap_lo[i])
					cap_lock_reg[i] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_reload;
		reload |=> count_reg == frt_pkg::COUNT_RESET;
	endproperty
	a_reload: assert property (p_reload) else $error("counter not reloaded"); // [RQ8]

	property p_wrap;
		(tick && !reload && count_reg == frt_pkg::COUNT_TOP) |=>
			flag_reg[frt_pkg::ST_WRAP] && count_reg == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap did not set flag"); // [RQ12]

	property p_hold;
		(!tick && !reload) |=> $stable(count_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved without step"); // [RQ1]

	property p_halt;
		halt_mode |-> !tick;
	endproperty
	a_halt: assert property (p_halt) else $error("count stepped in halt"); // [RQ15]

	property p_div2;
		(!halt_mode && clk_sel == frt_pkg::FRT_CLK_DIV2 && tick) ##1
			(!halt_mode && clk_sel == frt_pkg::FRT_CLK_DIV2)[*2] |-> tick;
	endproperty
	a_div2: assert property (p_div2) else $error("divide by two rate wrong"); // [RQ2]

	property p_buf_frozen;
		(buf_valid_reg[0] && !rd_cnt_lo) |=> buf_valid_reg[0] && $stable(lo_buf_reg[0]);
	endproperty
	a_buf_frozen: assert property (p_buf_frozen) else $error("low byte buffer changed"); // [RQ10]

	property p_wrap_keep;
		(flag_reg[frt_pkg::ST_WRAP] && !arm_reg[frt_pkg::ST_WRAP]) |=> flag_reg[frt_pkg::ST_WRAP];
	endproperty
	a_wrap_keep: assert property (p_wrap_keep) else $error("wrap flag cleared without status read"); // [RQ14]

	property p_shadow_keep;
		(flag_reg[frt_pkg::ST_WRAP] && rd_shd_lo) |=> flag_reg[frt_pkg::ST_WRAP];
	endproperty
	a_shadow_keep: assert property (p_shadow_keep) else $error("shadow read cleared wrap flag"); // [RQ7]

	property p_capture;
		pin_edge[2] && !cap_lock_reg[1] |=>
			capture_value_reg[1] == $past(count_reg) && flag_reg[frt_pkg::ST_CAP_TWO];
	endproperty
	a_capture: assert property (p_capture) else $error("capture two missed"); // [RQ16]

	property p_lock;
		cap_lock_reg[0] |=> $stable(capture_value_reg[0]);
	endproperty
	a_lock: assert property (p_lock) else $error("locked capture changed"); // [RQ20]

	property p_pulse_mode;
		pulse_mode |=> $stable(capture_value_reg[0]);
	endproperty
	a_pulse_mode: assert property (p_pulse_mode) else $error("channel one captured in pulse mode"); // [RQ22]

	property p_irq;
		(flag_reg[frt_pkg::ST_WRAP] && timer_control_one[frt_pkg::C1_WRAP_IE] && !cpu_irq_mask) |-> timer_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("pending wrap not requested"); // [RQ13]

	property p_rd_answer;
		rd_do |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

	c_wrap:    cover property (wrap_evt);
	c_cap_two: cover property (cap_take[1]);
	c_ext:     cover property (use_ext && tick);
	c_clear:   cover property (sts_rd ##[1:20] clr_fire[2]);

endmodule // frt_timer

// ---- dv/frt_pin_model.sv ----
// pin side partner: external count clock and the two capture pins.
// assumes toggle() is called right after a rising edge of aclk.
`timescale 1ns/100ps

module frt_pin_model (
	input  wire logic aclk,
	output logic      ext_clock_pin,
	output logic      capture_pin_one,
	output logic      capture_pin_two
);
	// all pins bonded and idle low
	initial begin
		ext_clock_pin   = 1'b0;
		capture_pin_one = 1'b0;
		capture_pin_two = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// each level stands four clocks, so active edges sit eight clocks apart
	task automatic toggle(input int pin, input int n);
		for (int i = 0; i < n; i++) begin
			case (pin)
				0: ext_clock_pin <= ~ext_clock_pin;
				1: capture_pin_one <= ~capture_pin_one;
				default: capture_pin_two <= ~capture_pin_two;
			endcase
			repeat (4) @(posedge aclk);
		end
		// extra wait covers the synchroniser delay
		repeat (4) @(posedge aclk);
	endtask
endmodule // frt_pin_model

// ---- dv/tb_free_running_timer_capture.sv ----
// bench for the free running timer: axi reads queue expectations, a monitor compares.
// assumes frt_pkg offsets and the hand-over timing of the register bus.
`timescale 1ns/100ps

module tb_free_running_timer_capture;
	typedef struct {
		logic [33:0] v;
		int          tol;
	} frt_exp_t;

	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, halt_mode, cpu_irq_mask, timer_irq;
	logic        ext_clock_pin, capture_pin_one, capture_pin_two;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	frt_exp_t    exp_q[$];
	frt_exp_t    e;
	int          n_errors, samples_checked;

	frt_timer u_frt_timer (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_clock_pin(ext_clock_pin), .capture_pin_one(capture_pin_one),
		.capture_pin_two(capture_pin_two), .halt_mode(halt_mode),
		.cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq)
	);

	frt_pin_model u_frt_pin_model (
		.aclk(aclk), .ext_clock_pin(ext_clock_pin),
		.capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two)
	);

	// 50 MHz clock
	initial aclk = 1'b0;
	always #10 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////////
	// tolerance absorbs prescaler phase; unknowns never match
	task automatic chk(input logic [33:0] x, input logic [33:0] g, input int tol);
		samples_checked++;
		if (^g === 1'bx || (g > x ? g - x : x - g) > tol) begin
			n_errors++;
			$display("BAD t=%0t exp=%h got=%h", $time, x, g);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// ready sampled at the falling edge, taken at the next rising edge;
	// bready and rready are driven high by every wr and rd call and never lowered, so they stay high between transfers
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs = frt_pkg::RESP_OKAY);
		logic aw_hit, w_hit, b_hit;
		awaddr  <= a;
		wdata   <= {24'h0, d};
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (int t = 0; t <= 100; t++) begin
			if (t == 100) begin
				n_errors++;
				test_done();
			end
			@(negedge aclk);
			aw_hit = awvalid & awready;
			w_hit  = wvalid & wready;
			b_hit  = bvalid;
			@(posedge aclk);
			if (aw_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
			if (b_hit) begin
				chk({32'h0, rs}, {32'h0, bresp}, 0);
				break;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] x, input int tol,
		input logic [1:0] rs = frt_pkg::RESP_OKAY);
		logic a_hit, r_hit;
		exp_q.push_back('{v: {rs, 24'h0, x}, tol: tol});
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (int t = 0; t <= 100; t++) begin
			if (t == 100) begin
				n_errors++;
				test_done();
			end
			@(negedge aclk);
			a_hit = arvalid & arready;
			r_hit = rvalid;
			@(posedge aclk);
			if (a_hit) arvalid <= 1'b0;
			if (r_hit) begin
				break;
			end
		end
	endtask

	task automatic irq_is(input logic x);
		@(negedge aclk);
		chk({33'h0, x}, {33'h0, timer_irq}, 0);
		@(posedge aclk);
	endtask

	// read monitor takes the oldest note at each read handshake
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk(e.v, {rresp, rdata}, e.tol);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence; counter held by halt until the prescaler test
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_irq_mask} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		halt_mode = 1'b1;
		n_errors = 0;
		samples_checked = 0;
		void'($urandom(70));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(frt_pkg::OFF_CTRL_ONE, 8'h00, 0);
		rd(frt_pkg::OFF_CTRL_TWO, 8'h00, 0);
		rd(frt_pkg::OFF_STATUS, 8'h00, 0);
		rd(frt_pkg::OFF_CNT_HI, 8'hFF, 0);
		rd(frt_pkg::OFF_CNT_LO, 8'hFC, 0);
		rd(frt_pkg::OFF_SHD_HI, 8'hFF, 0);
		rd(frt_pkg::OFF_SHD_LO, 8'hFC, 0);
		rd(8'h3C, 8'h00, 0, frt_pkg::RESP_SLVERR);
		wr(8'h3C, 8'($urandom), frt_pkg::RESP_SLVERR);
		$display("test reset done");
		for (int s = 0; s < 3; s++) begin
			wr(frt_pkg::OFF_CTRL_TWO, 8'(s));
			wr(frt_pkg::OFF_CNT_LO, 8'($urandom));
			halt_mode <= 1'b0;
			repeat (128) @(posedge aclk);
			halt_mode <= 1'b1;
			rd(frt_pkg::OFF_CNT_LO, 8'(8'hFC + (128 >> (s + 1))), 1);
		end
		rd(frt_pkg::OFF_CNT_HI, 8'h00, 0);
		wr(frt_pkg::OFF_CTRL_TWO, 8'h00);
		halt_mode <= 1'b0;
		repeat (40) @(posedge aclk);
		halt_mode <= 1'b1;
		rd(frt_pkg::OFF_CNT_HI, 8'h00, 0);
		rd(frt_pkg::OFF_CNT_LO, 8'h0C, 1);
		rd(frt_pkg::OFF_CNT_LO, 8'h20, 1);
		$display("test prescaler done");
		wr(frt_pkg::OFF_CTRL_ONE, 8'h02);
		irq_is(1'b1);
		cpu_irq_mask <= 1'b1;
		irq_is(1'b0);
		cpu_irq_mask <= 1'b0;
		rd(frt_pkg::OFF_STATUS, 8'h04, 0);
		rd(frt_pkg::OFF_SHD_LO, 8'h20, 0);
		rd(frt_pkg::OFF_STATUS, 8'h04, 0);
		rd(frt_pkg::OFF_CNT_LO, 8'h20, 0);
		rd(frt_pkg::OFF_STATUS, 8'h00, 0);
		irq_is(1'b0);
		$display("test wrap done");
		halt_mode <= 1'b0;
		wr(frt_pkg::OFF_CTRL_TWO, 8'h0B);
		wr(frt_pkg::OFF_CNT_LO, 8'($urandom));
		u_frt_pin_model.toggle(0, 5);
		rd(frt_pkg::OFF_CNT_HI, 8'hFF, 0);
		rd(frt_pkg::OFF_CNT_LO, 8'hFF, 0);
		wr(frt_pkg::OFF_CTRL_TWO, 8'h03);
		wr(frt_pkg::OFF_SHD_LO, 8'($urandom));
		u_frt_pin_model.toggle(0, 5);
		rd(frt_pkg::OFF_CNT_HI, 8'hFF, 0);
		rd(frt_pkg::OFF_CNT_LO, 8'hFF, 0);
		$display("test external clock done");
		wr(frt_pkg::OFF_CTRL_ONE, 8'h05);
		u_frt_pin_model.toggle(1, 2);
		irq_is(1'b1);
		rd(frt_pkg::OFF_STATUS, 8'h01, 0);
		rd(frt_pkg::OFF_CAP1_HI, 8'hFF, 0);
		u_frt_pin_model.toggle(0, 2);
		u_frt_pin_model.toggle(1, 2);
		rd(frt_pkg::OFF_CAP1_LO, 8'hFF, 0);
		rd(frt_pkg::OFF_STATUS, 8'h04, 0);
		u_frt_pin_model.toggle(2, 2);
		u_frt_pin_model.toggle(0, 2);
		u_frt_pin_model.toggle(2, 2);
		wr(frt_pkg::OFF_CTRL_TWO, 8'h13);
		u_frt_pin_model.toggle(1, 2);
		wr(frt_pkg::OFF_CTRL_TWO, 8'h23);
		u_frt_pin_model.toggle(1, 2);
		rd(frt_pkg::OFF_STATUS, 8'h06, 0);
		rd(frt_pkg::OFF_CAP2_HI, 8'h00, 0);
		rd(frt_pkg::OFF_CAP2_LO, 8'h01, 0);
		rd(frt_pkg::OFF_STATUS, 8'h04, 0);
		$display("test capture done");
		test_done();
	end
endmodule // tb_free_running_timer_capture
